// File: core/odf_serial_port.sv
// Serial register port: shifts the 16-bit command word and serves read back
`timescale 1ns/1ps
module odf_serial_port (
   input  wire logic            ref_clk,
   input  wire logic            reset_n,
   input  wire logic            csSyncN,
   input  wire logic            sckRise,
   input  wire logic            sckFall,
   input  wire logic            sdiSync,
   input  wire logic [7:0]      readData,
   output logic                 wordDone,
   output logic                 wordRead,
   output logic [6:0]           wordAddr,
   output logic [7:0]           wordData,
   output logic                 sdoOutEnN
);
   import odf_pkg::*;

   logic [WORD_BITS-1:0] shift_ff;
   logic [4:0]           count_ff;
   logic [7:0]           rdShift_ff;
   logic                 sdoLow_ff;
   logic                 csPrev_ff;
   logic                 done_ff;
   logic [6:0]           addr_ff;
   logic                 rw_ff;

   // ****************************************************************
   // Input shift: rw bit, address, data in that order
   // ****************************************************************
   // Edges past the sixteenth are ignored; count saturates
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_ff <= '0;
         count_ff <= '0;
      end else if (csSyncN) begin
         count_ff <= '0;
      end else if (sckRise && count_ff < 5'(WORD_BITS)) begin
         shift_ff <= {shift_ff[WORD_BITS-2:0], sdiSync};
         count_ff <= count_ff + 5'h01;
      end
   end

   // Address and rw bit held from the eighth edge, so read back can use them mid-frame
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_ff <= '0;
         rw_ff   <= 1'b0;
      end else if (sckRise && count_ff == 5'h07) begin
         addr_ff <= {shift_ff[5:0], sdiSync};
         rw_ff   <= shift_ff[6];
      end
   end

   // Word completes when select rises after a full word
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         csPrev_ff <= 1'b1;
         done_ff   <= 1'b0;
      end else begin
         csPrev_ff <= csSyncN;
         done_ff   <= csSyncN && !csPrev_ff && count_ff == 5'(WORD_BITS);
      end
   end

   assign wordDone = done_ff;
   assign wordRead = rw_ff;
   assign wordAddr = addr_ff;
   assign wordData = shift_ff[7:0];

   // ****************************************************************
   // Read back on the open-drain output
   // ****************************************************************
   // Data loaded after the eighth bit, shifted out on falling edges
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdShift_ff <= '0;
         sdoLow_ff  <= 1'b0;
      end else if (csSyncN) begin
         sdoLow_ff <= 1'b0;
      end else if (sckFall && count_ff == 5'h08 && rw_ff) begin
         rdShift_ff <= {readData[6:0], 1'b0};
         sdoLow_ff  <= !readData[7];
      end else if (sckFall && rw_ff && count_ff > 5'h08 && count_ff < 5'(WORD_BITS)) begin
         sdoLow_ff  <= !rdShift_ff[7];
         rdShift_ff <= {rdShift_ff[6:0], 1'b0};
      end
   end

   // Enable low pulls the line low
   assign sdoOutEnN = !sdoLow_ff;
endmodule : odf_serial_port

// File: core/output_data_format_control.sv
// Format register and output pattern stage of the sampling converter
`timescale 1ns/1ps
module output_data_format_control (
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   input  wire logic                  csPinN,
   input  wire logic                  sckPin,
   input  wire logic                  sdiPin,
   output logic                       sdoOut,
   output logic                       sdoOutEnN,
   input  wire odf_pkg::odf_sample_t  sampleIn,
   output odf_pkg::odf_sample_t       sampleOut,
   output logic                       alternatePolarityEnable,
   output logic                       outputScramblerEnable,
   output logic                       signedCodingSelect
);
   import odf_pkg::*;

   logic [2:0]  csSync_ff, sckSync_ff;
   logic [1:0]  sdiSync_ff;
   logic        wordDone, wordRead;
   logic [6:0]  wordAddr;
   logic [7:0]  wordData;
   odf_format_t format_ff;
   logic        phase_ff;
   logic [SAMPLE_BITS:0] word, coded;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Third stage only feeds edge detection, never the first stage
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         csSync_ff  <= 3'h7;
         sckSync_ff <= 3'h0;
         sdiSync_ff <= 2'h0;
      end else begin
         csSync_ff  <= {csSync_ff[1:0], csPinN};
         sckSync_ff <= {sckSync_ff[1:0], sckPin};
         sdiSync_ff <= {sdiSync_ff[0], sdiPin};
      end
   end

   odf_serial_port u_port (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .csSyncN   (csSync_ff[1]),
      .sckRise   (sckSync_ff[1] && !sckSync_ff[2]),
      .sckFall   (!sckSync_ff[1] && sckSync_ff[2]),
      .sdiSync   (sdiSync_ff[1]),
      .readData  (wordAddr == ADDR_DATA_FORMAT ? format_ff & FORMAT_USED_MASK : 8'h00),
      .wordDone  (wordDone),
      .wordRead  (wordRead),
      .wordAddr  (wordAddr),
      .wordData  (wordData),
      .sdoOutEnN (sdoOutEnN)
   );

   assign sdoOut = 1'b0;

   // ****************************************************************
   // Format register
   // ****************************************************************
   // Updated only when a full write word completes, so no sample sees half a write
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         format_ff <= FORMAT_RESET;
      end else if (wordDone && !wordRead) begin
         if (wordAddr == ADDR_SW_RESET && wordData[SW_RESET_BIT]) begin
            format_ff <= FORMAT_RESET;
         end else if (wordAddr == ADDR_DATA_FORMAT) begin
            format_ff <= wordData;
         end
      end
   end

   // Mode bits go to the downstream coding, polarity and scrambler stages
   assign alternatePolarityEnable = format_ff.alternatePolarityEnable;
   assign outputScramblerEnable   = format_ff.outputScramblerEnable;
   assign signedCodingSelect      = format_ff.signedCodingSelect;

   // Sample phase for alternating patterns
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_ff <= 1'b0;
      end else begin
         phase_ff <= !phase_ff;
      end
   end

   // ****************************************************************
   // Data path: coding, scrambling, polarity, test patterns
   // ****************************************************************
   always_comb begin
      coded = sampleIn;
      if (format_ff.signedCodingSelect) begin
         coded = coded ^ SIGN_FLIP;
      end
      if (format_ff.outputScramblerEnable) begin
         coded = coded ^ ({SAMPLE_BITS+1{coded[0]}} & LSB_MASK);
      end
      if (format_ff.alternatePolarityEnable) begin
         coded = coded ^ ABP_MASK;
      end
      // Undefined codes fall back to normal data; host must avoid them
      case (format_ff.testPatternSelect)
         PAT_OFF:     word = coded;
         PAT_ZEROS:   word = ALL_ZEROS;
         PAT_ONES:    word = ALL_ONES;
         PAT_CHECKER: word = phase_ff ? ~CHECKER_WORD : CHECKER_WORD;
         PAT_TOGGLE:  word = phase_ff ? ALL_ONES : ALL_ZEROS;
         default:     word = coded;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sampleOut <= '0;
      end else begin
         sampleOut <= word;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_zeros;
      @(posedge ref_clk) disable iff (!reset_n)
      format_ff.testPatternSelect == PAT_ZEROS |=> sampleOut == ALL_ZEROS;
   endproperty
   a_zeros: assert property (p_zeros) else $error("zeros pattern wrong");

   property p_ones;
      @(posedge ref_clk) disable iff (!reset_n)
      format_ff.testPatternSelect == PAT_ONES |=> sampleOut == ALL_ONES;
   endproperty
   a_ones: assert property (p_ones) else $error("ones pattern wrong");

   sequence s_checker2;
      (format_ff.testPatternSelect == PAT_CHECKER) [*2];
   endsequence
   property p_checker;
      @(posedge ref_clk) disable iff (!reset_n)
      s_checker2 |=> sampleOut == ~$past(sampleOut) && (sampleOut == CHECKER_WORD || sampleOut == ~CHECKER_WORD);
   endproperty
   a_checker: assert property (p_checker) else $error("checkerboard wrong");

   property p_toggle;
      @(posedge ref_clk) disable iff (!reset_n)
      (format_ff.testPatternSelect == PAT_TOGGLE) [*2] |=> sampleOut == ~$past(sampleOut);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle pattern wrong");

   property p_pass;
      @(posedge ref_clk) disable iff (!reset_n)
      format_ff == 8'h00 |=> sampleOut == $past(sampleIn);
   endproperty
   a_pass: assert property (p_pass) else $error("normal data not passed");

   property p_write;
      @(posedge ref_clk) disable iff (!reset_n)
      wordDone && !wordRead && wordAddr == ADDR_DATA_FORMAT |=> format_ff == $past(wordData);
   endproperty
   a_write: assert property (p_write) else $error("format write lost");

   property p_swreset;
      @(posedge ref_clk) disable iff (!reset_n)
      wordDone && !wordRead && wordAddr == ADDR_SW_RESET && wordData[SW_RESET_BIT] |=> format_ff == FORMAT_RESET;
   endproperty
   a_swreset: assert property (p_swreset) else $error("software reset missed");

   property p_stable;
      @(posedge ref_clk) disable iff (!reset_n)
      !wordDone || wordRead |=> $stable(format_ff);
   endproperty
   a_stable: assert property (p_stable) else $error("format changed without write");

   property p_modes;
      @(posedge ref_clk) disable iff (!reset_n)
      signedCodingSelect == format_ff[0] && outputScramblerEnable == format_ff[1]
         && alternatePolarityEnable == format_ff[2];
   endproperty
   a_modes: assert property (p_modes) else $error("mode outputs wrong");
endmodule : output_data_format_control

// File: inc/odf_pkg.sv
// Package of constants and types for the output data format control block
package odf_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [6:0] ADDR_SW_RESET    = 7'h00;
   localparam logic [6:0] ADDR_DATA_FORMAT = 7'h04;
   localparam int         SW_RESET_BIT     = 7;
   localparam logic [7:0] FORMAT_RESET     = 8'h00;
   localparam logic [7:0] FORMAT_USED_MASK = 8'h3f;
   localparam int         WORD_BITS        = 16;
   localparam int         SAMPLE_BITS      = 14;

   // ****************************************************************
   // Field layout and pattern codes
   // ****************************************************************
   typedef enum logic [2:0] {
      PAT_OFF     = 3'h0,
      PAT_ZEROS   = 3'h1,
      PAT_ONES    = 3'h3,
      PAT_CHECKER = 3'h5,
      PAT_TOGGLE  = 3'h7
   } odf_pattern_t;

   typedef struct packed {
      logic [1:0]   unused;
      odf_pattern_t testPatternSelect;
      logic         alternatePolarityEnable;
      logic         outputScramblerEnable;
      logic         signedCodingSelect;
   } odf_format_t;

   typedef struct packed {
      logic                   overrangeFlag;
      logic [SAMPLE_BITS-1:0] sampleBits;
   } odf_sample_t;

   localparam logic [SAMPLE_BITS:0] CHECKER_WORD = 15'h5555;
   localparam logic [SAMPLE_BITS:0] ALL_ONES     = 15'h7fff;
   localparam logic [SAMPLE_BITS:0] ALL_ZEROS    = 15'h0000;
   localparam logic [SAMPLE_BITS:0] SIGN_FLIP    = 15'h2000;
   localparam logic [SAMPLE_BITS:0] ABP_MASK     = 15'h2aaa;
   localparam logic [SAMPLE_BITS:0] LSB_MASK     = 15'h3ffe;
   localparam logic [SAMPLE_BITS:0] LSB_ONLY     = 15'h0001;
endpackage : odf_pkg

// File: testbench/odf_sample_rx.sv
// Receiver model that captures the formatted sample stream
`timescale 1ns/1ps
module odf_sample_rx (
   input  wire logic            ref_clk,
   input  wire logic            reset_n,
   input  wire odf_pkg::odf_sample_t sampleOut,
   output odf_pkg::odf_sample_t curWord_ff,
   output odf_pkg::odf_sample_t prvWord_ff
);
   import odf_pkg::*;
   // Two words kept, so an alternating pattern is judged as a pair
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         curWord_ff <= '0;
         prvWord_ff <= '0;
      end else begin
         curWord_ff <= sampleOut;
         prvWord_ff <= curWord_ff;
      end
   end
endmodule : odf_sample_rx

// File: testbench/tb_top.sv
// Self-checking bench for the output data format control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
   import odf_pkg::*;
   // **********************************************************
   // Signals and instances
   // **********************************************************
   logic        ref_clk, reset_n, csPinN, sckPin, sdiPin;
   logic        sdoOut, sdoOutEnN, apEn, scEn, sgSel;
   logic [7:0]  rdBits;
   int          err_count, n_compared, cycles;
   odf_sample_t sampleIn, sampleOut, curWord, prvWord;
   wire logic   sdoLine = sdoOutEnN ? 1'b1 : sdoOut; // Pull-up on the open-drain line
   output_data_format_control output_data_format_control_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .csPinN(csPinN), .sckPin(sckPin), .sdiPin(sdiPin), .sdoOut(sdoOut), .sdoOutEnN(sdoOutEnN),
      .sampleIn(sampleIn), .sampleOut(sampleOut), .alternatePolarityEnable(apEn),
      .outputScramblerEnable(scEn), .signedCodingSelect(sgSel));
   odf_sample_rx odf_sample_rx_inst (.ref_clk(ref_clk), .reset_n(reset_n), .sampleOut(sampleOut),
      .curWord_ff(curWord), .prvWord_ff(prvWord));
   // **********************************************************
   // Serial host tasks
   // **********************************************************
   task automatic tk(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tk
   // Slow sck (8 clocks a level) so the pin synchronisers never miss an edge
   task automatic spi_bits(input logic [15:0] w, input int n);
      csPinN = 1'b0;
      tk(4);
      for (int i = 0; i < n; i++) begin
         sdiPin = w[15-i];
         tk(8);
         rdBits = {rdBits[6:0], sdoLine};
         sckPin = 1'b1;
         tk(8);
         sckPin = 1'b0;
      end
      tk(8);
   endtask : spi_bits
   task automatic spi_end();
      csPinN = 1'b1;
      sdiPin = 1'b0;
      tk(8);
   endtask : spi_end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      spi_bits({1'b0, a, d}, 16);
      spi_end();
   endtask : wr
   // Data bits of a read are all ones, which must not reach the register
   task automatic chk_fmt(input logic [7:0] e);
      spi_bits({1'b1, ADDR_DATA_FORMAT, 8'hff}, 16);
      spi_end();
      `CHK("format readback", e[5:0], rdBits[5:0])
      `CHK("mode outputs", e[2:0], {apEn, scEn, sgSel})
   endtask : chk_fmt
   // **********************************************************
   // Scenarios
   // **********************************************************
   task automatic t_patterns();
      `CHK("normal data", 15'h4321, sampleOut)
      // Only the five defined pattern codes are ever written
      wr(ADDR_DATA_FORMAT, 8'h08);
      `CHK("all zeros", 15'h0000, sampleOut)
      wr(ADDR_DATA_FORMAT, 8'hd8); // Upper two bits set, they must be ignored
      `CHK("all ones", 15'h7fff, sampleOut)
      chk_fmt(8'h18);
      wr(ADDR_DATA_FORMAT, 8'h28);
      `CHK("checker", 1'b1, {curWord, prvWord} inside {{15'h2aaa, 15'h5555}, {15'h5555, 15'h2aaa}})
      wr(ADDR_DATA_FORMAT, 8'h38);
      `CHK("toggle", 1'b1, {curWord, prvWord} inside {{15'h0000, 15'h7fff}, {15'h7fff, 15'h0000}})
      wr(ADDR_DATA_FORMAT, 8'h00);
      `CHK("normal again", 15'h4321, sampleOut)
   endtask : t_patterns
   task automatic t_modes();
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_DATA_FORMAT, 8'h01 << i);
         chk_fmt(8'h01 << i);
         if (i == 0) `CHK("signed coding", 15'h6321, sampleOut)
      end
      wr(ADDR_DATA_FORMAT, 8'h00);
      chk_fmt(8'h00);
   endtask : t_modes
   // Short frame, other address and a read all leave the register alone
   task automatic t_refused();
      wr(ADDR_DATA_FORMAT, 8'h08);
      spi_bits({1'b0, ADDR_DATA_FORMAT, 8'h18}, 8);
      spi_end();
      wr(7'h05, 8'h18);
      `CHK("refused word", 15'h0000, sampleOut)
      chk_fmt(8'h08);
   endtask : t_refused
   task automatic t_late_apply();
      spi_bits({1'b0, ADDR_DATA_FORMAT, 8'h18}, 16);
      `CHK("before select ends", 15'h0000, sampleOut)
      spi_end();
      `CHK("after select ends", 15'h7fff, sampleOut)
   endtask : t_late_apply
   task automatic t_soft_reset();
      wr(ADDR_SW_RESET, 8'h80);
      chk_fmt(8'h00);
      `CHK("data after reset", 15'h4321, sampleOut)
   endtask : t_soft_reset
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   // **********************************************************
   // Clock, timeout and main sequence
   // **********************************************************
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // A run of about 6000 cycles is expected; the ceiling leaves ample margin
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      {err_count, n_compared, cycles} = '0;
      {reset_n, sckPin, sdiPin, rdBits} = '0;
      csPinN = 1'b1;
      sampleIn = 15'h4321;
      tk(16);
      reset_n = 1'b1;
      tk(4);
      chk_fmt(8'h00);
      t_patterns();
      t_modes();
      t_refused();
      t_late_apply();
      t_soft_reset();
      stop_test();
   end
endmodule : tb_top
